// file: rtl/umsi_pkg.sv
// Purpose: constants for the uart modem-status and interrupt block
// Assumes: one clock (hclk, 100 MHz), registers reached over AHB-Lite
// Notes: each register takes one aligned 32-bit word, data in bits 7:0
// Summary of operation
// R1: normally status bits 7..4 are inverted cd, ri, dsr, cts input levels
// R2: in loopback bits 7,6,5,4 follow modem control bits 3,2,0,1
// R3: cd, dsr, cts change flags set on either edge of their source
// R4: ring change flag sets only when ring source goes low to high
// R5: reading modem line state clears bits 3..0; bits 7..4 stay live
// R6: mask bits 0..3 enable rx data, tx holding, line status, modem irqs
// R7: mask bit 5 xoff/special, bit 6 rts change, bit 7 cts change; code lets bit 6 or 7 enable the one flow rise source
// R8: mask bit 4 set puts the channel into sleep mode
// R9: mask bits 7..4 writable only while enhanced feature bit 4 is one
// R10: re-enabling tx holding irq raises no new irq by itself
// R11: mask register resets to zero
// R12: interrupt output active whenever an enabled condition is pending
// R13: source register read-only; bit 0 is zero while irq pending
// R14: source bits 7 and 6 mirror fifo enable bit 0
// R15: codes 000110 line,001100 timeout,000100 rx,000010 tx,000000 modem
// R16: priority line, rx/timeout, tx, modem, xoff, flow change lowest
// R17: xoff/special source reads bit 4 one, other low bits zero
// R18: rts/cts low-to-high change reads bit 5 one, others zero
// R19: modem control bit 4 selects loopback of the modem status inputs
// R20: only enabled sources reported; next lower shown when top clears
package umsi_pkg;
   localparam logic [7:0] UMSI_OFS_LINE_STATE = 8'h00;
   localparam logic [7:0] UMSI_OFS_MASK = 8'h04;
   localparam logic [7:0] UMSI_OFS_SOURCE = 8'h08;
   localparam logic [7:0] UMSI_OFS_MODEM_CTRL = 8'h0C;
   localparam logic [7:0] UMSI_OFS_ENH_FEAT = 8'h10;
   localparam logic [7:0] UMSI_OFS_FIFO_CTRL = 8'h14;
   localparam logic [7:0] UMSI_RST_MASK = 8'h00;
   localparam logic [7:0] UMSI_RST_CTRL = 8'h00;
   localparam int UMSI_ENH_BIT = 4;
   localparam int UMSI_LOOP_BIT = 4;
   localparam int UMSI_SLEEP_BIT = 4;
   localparam int UMSI_FIFO_EN_BIT = 0;
   localparam logic [5:0] UMSI_CODE_LINE = 6'h06;
   localparam logic [5:0] UMSI_CODE_TOUT = 6'h0C;
   localparam logic [5:0] UMSI_CODE_RX = 6'h04;
   localparam logic [5:0] UMSI_CODE_TX = 6'h02;
   localparam logic [5:0] UMSI_CODE_MODEM = 6'h00;
   localparam logic [5:0] UMSI_CODE_XOFF = 6'h10;
   localparam logic [5:0] UMSI_CODE_FLOW = 6'h20;
   localparam logic [5:0] UMSI_CODE_NONE = 6'h01;
   localparam logic [1:0] UMSI_HTRANS_NONSEQ = 2'h2;
endpackage

// file: rtl/umsi_top.sv
// Purpose: modem line status, interrupt mask, source id and irq output
// Assumes: event inputs come from logic on hclk; modem pins are asynchronous
// Notes: unmapped addresses read zero and ignore writes; response always OKAY
`timescale 1ns/1ps
module umsi_top
   import umsi_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic carrier_detect_in_n,
   input wire logic ring_indicator_in_n,
   input wire logic set_ready_in_n,
   input wire logic clear_to_send_in_n,
   input wire logic line_err_pend,
   input wire logic rx_timeout_pend,
   input wire logic rx_data_pend,
   input wire logic tx_level_event,
   input wire logic tx_holding_write,
   input wire logic xoff_detect,
   input wire logic flow_rise_event,
   output logic irq_out_a,
   output logic sleep_mode,
   output logic loopback_mode
);
   import umsi_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // bus address phase capture
   logic wr_pend;
   logic rd_pend;
   logic [7:0] addr_q;
   logic [7:0] modem_control_reg;
   logic [7:0] enhanced_feature_reg;
   logic [7:0] fifo_control_reg;
   logic [7:0] irq_mask_reg;
   logic [3:0] delta;
   logic tx_pend;
   logic flow_pend;
   logic xoff_pend;

   wire logic take = hsel && hready && htrans == UMSI_HTRANS_NONSEQ;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_pend <= take && hwrite;
         rd_pend <= take && !hwrite;
         if (take) begin
            addr_q <= haddr;
         end
      end
   end

   wire logic wr_mask = wr_pend && addr_q == UMSI_OFS_MASK;
   // read side effects act on the edge that captures hrdata, so no change is lost
   wire logic rd_msr = take && !hwrite && haddr == UMSI_OFS_LINE_STATE; // see R5
   wire logic rd_src = take && !hwrite && haddr == UMSI_OFS_SOURCE;

   ////////////////////////////////////////////////////////////////////////
   // modem pin synchronisers, two flops each
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1 <= 4'hF;
         pin_s2 <= 4'hF;
      end else begin
         pin_s1 <= {carrier_detect_in_n, ring_indicator_in_n, set_ready_in_n,
            clear_to_send_in_n};
         pin_s2 <= pin_s1;
      end
   end

   // live status: cd, ri, dsr, cts active high
   wire logic loop = modem_control_reg[UMSI_LOOP_BIT]; // see R19
   wire logic [3:0] live = loop ?
      {modem_control_reg[3], modem_control_reg[2], modem_control_reg[0],
       modem_control_reg[1]} : ~pin_s2; // see R1 see R2
   logic [3:0] live_q;

   ////////////////////////////////////////////////////////////////////////
   // control registers: modem control, enhanced feature, fifo control
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         modem_control_reg <= UMSI_RST_CTRL;
         enhanced_feature_reg <= UMSI_RST_CTRL;
         fifo_control_reg <= UMSI_RST_CTRL;
      end else if (wr_pend) begin
         if (addr_q == UMSI_OFS_MODEM_CTRL) begin
            modem_control_reg <= hwdata[7:0];
         end
         if (addr_q == UMSI_OFS_ENH_FEAT) begin
            enhanced_feature_reg <= hwdata[7:0];
         end
         if (addr_q == UMSI_OFS_FIFO_CTRL) begin
            fifo_control_reg <= hwdata[7:0];
         end
      end
   end

   // interrupt mask, upper nibble write-protected
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask_reg <= UMSI_RST_MASK; // see R11
      end else if (wr_mask) begin
         irq_mask_reg[3:0] <= hwdata[3:0];
         if (enhanced_feature_reg[UMSI_ENH_BIT]) begin
            irq_mask_reg[7:4] <= hwdata[7:4]; // see R9
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // change flags; a new change wins over the read clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         live_q <= 4'h0;
         delta <= 4'h0;
      end else begin
         live_q <= live;
         delta[3] <= (live[3] != live_q[3]) || (delta[3] && !rd_msr); // see R3
         delta[2] <= (live[2] && !live_q[2]) || (delta[2] && !rd_msr); // see R4
         delta[1] <= (live[1] != live_q[1]) || (delta[1] && !rd_msr); // see R3
         delta[0] <= (live[0] != live_q[0]) || (delta[0] && !rd_msr); // see R3
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event-held sources: tx holding, xoff, flow-line rise
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_pend <= 1'b0;
         xoff_pend <= 1'b0;
         flow_pend <= 1'b0;
      end else begin
         // only a level event sets it; re-enabling the mask does not
         // a source read clears only the source it reports
         tx_pend <= tx_level_event || (tx_pend && !tx_holding_write &&
            !(rd_src && code_q == UMSI_CODE_TX)); // see R10
         xoff_pend <= xoff_detect || (xoff_pend && !(rd_src &&
            code_q == UMSI_CODE_XOFF));
         flow_pend <= flow_rise_event || (flow_pend && !(rd_src &&
            code_q == UMSI_CODE_FLOW));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // priority encoder over enabled pending sources
   function automatic logic [5:0] pick(input logic [7:0] m, input logic ln,
      input logic to, input logic rx, input logic tx, input logic md,
      input logic xf, input logic fl);
      logic [5:0] c;
      c = UMSI_CODE_NONE;
      if (m[2] && ln) c = UMSI_CODE_LINE; // see R16
      else if (m[0] && to) c = UMSI_CODE_TOUT;
      else if (m[0] && rx) c = UMSI_CODE_RX;
      else if (m[1] && tx) c = UMSI_CODE_TX;
      else if (m[3] && md) c = UMSI_CODE_MODEM;
      else if (m[5] && xf) c = UMSI_CODE_XOFF; // see R17
      else if ((m[6] || m[7]) && fl) c = UMSI_CODE_FLOW; // see R18
      return c;
   endfunction

   wire logic [5:0] next_code = pick(irq_mask_reg, line_err_pend, rx_timeout_pend,
      rx_data_pend, tx_pend, |delta, xoff_pend, flow_pend); // see R6 see R7 see R20
   logic [5:0] code_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         code_q <= UMSI_CODE_NONE;
         irq_out_a <= 1'b0;
         sleep_mode <= 1'b0;
         loopback_mode <= 1'b0;
      end else begin
         code_q <= next_code; // see R15
         irq_out_a <= !next_code[0]; // see R12
         sleep_mode <= irq_mask_reg[UMSI_SLEEP_BIT]; // see R8
         loopback_mode <= loop; // see R19
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data and bus response
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         if (take && !hwrite) begin
            case (haddr)
               UMSI_OFS_LINE_STATE: hrdata <= {24'h0, live_q, delta}; // see R5
               UMSI_OFS_MASK: hrdata <= {24'h0, irq_mask_reg};
               UMSI_OFS_SOURCE: hrdata <= {24'h0, {2{fifo_control_reg[UMSI_FIFO_EN_BIT]}},
                  code_q}; // see R13 see R14
               UMSI_OFS_MODEM_CTRL: hrdata <= {24'h0, modem_control_reg};
               UMSI_OFS_ENH_FEAT: hrdata <= {24'h0, enhanced_feature_reg};
               UMSI_OFS_FIFO_CTRL: hrdata <= {24'h0, fifo_control_reg};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   AST_MASK_RESET: assert property (@(posedge hclk) $rose(hresetn) |->
      irq_mask_reg == 8'h00) else $error("mask not zero after reset"); // see R11
   AST_UPPER_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_mask && !enhanced_feature_reg[4] |=> $stable(irq_mask_reg[7:4]))
      else $error("upper mask bits changed while locked"); // see R9
   AST_IRQ_MATCH: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_out_a == !code_q[0]) else $error("irq output disagrees with id"); // see R12
   AST_LINE_TOP: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_mask_reg[2] && line_err_pend |=> code_q == 6'h06)
      else $error("line status not top priority"); // see R16
   AST_RI_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
      !delta[2] && live_q[2] && !live[2] |=> !delta[2])
      else $error("ring flag set on falling edge"); // see R4
   AST_CD_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
      live[3] != live_q[3] |=> delta[3]) else $error("cd change missed"); // see R3
   AST_READ_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_msr && live == live_q |=> delta == 4'h0)
      else $error("flags not cleared by read"); // see R5
   AST_LOOP_SRC: assert property (@(posedge hclk) disable iff (!hresetn)
      modem_control_reg[4] && $stable(modem_control_reg) |=>
      live_q[3] == $past(modem_control_reg[3])) else $error("loopback cd wrong"); // see R2
   AST_NO_MASKED: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_mask_reg == 8'h00 |=> code_q == 6'h01)
      else $error("masked source reported"); // see R20
   AST_NORMAL_LIVE: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
      !modem_control_reg[4] |=> live_q == ~$past(pin_s2))
      else $error("status bits not inverted pins");
   AST_RI_RISE: assert property (@(posedge hclk) disable iff (!hresetn) // see R4
      live[2] && !live_q[2] |=> delta[2])
      else $error("ring rise missed");
   AST_RX_MASKED: assert property (@(posedge hclk) disable iff (!hresetn) // see R6
      !irq_mask_reg[0] |=> code_q != 6'h04 && code_q != 6'h0C)
      else $error("masked receive source reported");
   AST_SLEEP_COPY: assert property (@(posedge hclk) disable iff (!hresetn) // see R8
      sleep_mode == $past(irq_mask_reg[4]))
      else $error("sleep output wrong");
   AST_TX_NO_NEW: assert property (@(posedge hclk) disable iff (!hresetn) // see R10
      !tx_pend && !tx_level_event |=> !tx_pend)
      else $error("tx pending rose without event");
   AST_IRQ_PEND: assert property (@(posedge hclk) disable iff (!hresetn) // see R12
      irq_mask_reg[0] && rx_data_pend |=> irq_out_a)
      else $error("irq output not raised");
   AST_SRC_READ: assert property (@(posedge hclk) disable iff (!hresetn) // see R14
      rd_pend && addr_q == UMSI_OFS_SOURCE |->
      hrdata[7:0] == {{2{$past(fifo_control_reg[0])}}, $past(code_q)})
      else $error("source read data wrong");
   AST_TOUT_CODE: assert property (@(posedge hclk) disable iff (!hresetn) // see R15
      irq_mask_reg[0] && rx_timeout_pend && !(irq_mask_reg[2] && line_err_pend)
      |=> code_q == 6'h0C) else $error("timeout code wrong");
   AST_XOFF_CODE: assert property (@(posedge hclk) disable iff (!hresetn) // see R17
      irq_mask_reg[3:0] == 4'h0 && irq_mask_reg[5] && xoff_pend |=> code_q == 6'h10)
      else $error("xoff code wrong");
   AST_FLOW_CODE: assert property (@(posedge hclk) disable iff (!hresetn) // see R18
      irq_mask_reg[3:0] == 4'h0 && !irq_mask_reg[5] && irq_mask_reg[7] && flow_pend
      |=> code_q == 6'h20) else $error("flow code wrong");
   AST_LOOP_COPY: assert property (@(posedge hclk) disable iff (!hresetn) // see R19
      loopback_mode == $past(modem_control_reg[4]))
      else $error("loopback output wrong");
endmodule

// file: sim/tb_umsi_top.sv
// Purpose: register-level tests of modem status, mask and source id
// Assumes: zero wait AHB-Lite slave, hready fed back from hreadyout
// Notes: event inputs driven as levels {line, timeout, rx} and pulses
`timescale 1ns/1ps
module tb_umsi_top;
   import umsi_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd_val;
   logic hreadyout, hresp, irq_out_a, sleep_mode, loopback_mode;
   logic [2:0] lv = 3'h0;
   logic [2:0] pulses = 3'h0;
   logic tx_holding_write = 1'b0;
   logic [3:0] lines = 4'h0;
   logic cd_n, ri_n, dsr_n, cts_n;
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [11:0] pin_tab [7] = '{12'h888, 12'h880, 12'h008, 12'h444, 12'h000, 12'h333, 12'h003};
   always #5 hclk = ~hclk;
   umsi_modem_model umsi_modem_model_inst (.hclk(hclk), .lines(lines),
      .carrier_detect_in_n(cd_n), .ring_indicator_in_n(ri_n),
      .set_ready_in_n(dsr_n), .clear_to_send_in_n(cts_n));
   umsi_top umsi_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .carrier_detect_in_n(cd_n), .ring_indicator_in_n(ri_n), .set_ready_in_n(dsr_n),
      .clear_to_send_in_n(cts_n), .line_err_pend(lv[2]), .rx_timeout_pend(lv[1]),
      .rx_data_pend(lv[0]), .tx_level_event(pulses[0]), .tx_holding_write(tx_holding_write),
      .xoff_detect(pulses[1]), .flow_rise_event(pulses[2]), .irq_out_a(irq_out_a),
      .sleep_mode(sleep_mode), .loopback_mode(loopback_mode));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one single transfer: address phase, then data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= UMSI_HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd_val = hrdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rd_val, {24'h0, exp});
      chk({31'h0, hresp}, 32'h0);
   endtask
   // let an event settle, then check output and source id
   task automatic look(input logic [7:0] src, input logic irq);
      repeat (4) @(posedge hclk);
      chk({31'h0, irq_out_a}, {31'h0, irq});
      rdc(UMSI_OFS_SOURCE, src);
   endtask
   task automatic pulse(input logic [2:0] p);
      @(posedge hclk) pulses <= p;
      @(posedge hclk) pulses <= 3'h0;
   endtask
   // hang guard
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(UMSI_OFS_MASK, 8'h00);
      look(8'h01, 1'b0);
      $display("reset test done");
      for (int i = 0; i < 7; i++) begin
         lines <= pin_tab[i][11:8];
         repeat (6) @(posedge hclk);
         rdc(UMSI_OFS_LINE_STATE, pin_tab[i][7:0]);
      end
      $display("pin test done");
      bus(1'b1, UMSI_OFS_MODEM_CTRL, 8'h1F);
      repeat (4) @(posedge hclk);
      rdc(UMSI_OFS_LINE_STATE, 8'hFF);
      chk({31'h0, loopback_mode}, 32'h1);
      bus(1'b1, UMSI_OFS_MODEM_CTRL, 8'h1A);
      repeat (4) @(posedge hclk);
      rdc(UMSI_OFS_LINE_STATE, 8'h92);
      bus(1'b1, UMSI_OFS_MODEM_CTRL, 8'h00);
      repeat (4) @(posedge hclk);
      rdc(UMSI_OFS_LINE_STATE, 8'h09);
      $display("loopback test done");
      bus(1'b1, UMSI_OFS_MASK, 8'hFF);
      rdc(UMSI_OFS_MASK, 8'h0F);
      bus(1'b1, UMSI_OFS_ENH_FEAT, 8'h10);
      bus(1'b1, UMSI_OFS_MASK, 8'hFF);
      rdc(UMSI_OFS_MASK, 8'hFF);
      chk({31'h0, sleep_mode}, 32'h1);
      bus(1'b1, UMSI_OFS_MASK, 8'h00);
      lv <= 3'b001;
      look(8'h01, 1'b0);
      chk({31'h0, sleep_mode}, 32'h0);
      $display("mask test done");
      bus(1'b1, UMSI_OFS_FIFO_CTRL, 8'h01);
      bus(1'b1, UMSI_OFS_MASK, 8'hEF);
      lines <= 4'h1;
      lv <= 3'b101;
      repeat (4) @(posedge hclk);
      look(8'hC6, 1'b1);
      lv <= 3'b001;
      look(8'hC4, 1'b1);
      lv <= 3'b000;
      look(8'hC0, 1'b1);
      rdc(UMSI_OFS_LINE_STATE, 8'h11);
      look(8'hC1, 1'b0);
      lv <= 3'b010;
      look(8'hCC, 1'b1);
      lv <= 3'b000;
      pulse(3'b001);
      look(8'hC2, 1'b1);
      pulse(3'b010);
      look(8'hD0, 1'b1);
      pulse(3'b100);
      look(8'hE0, 1'b1);
      pulse(3'b001);
      @(posedge hclk) tx_holding_write <= 1'b1;
      @(posedge hclk) tx_holding_write <= 1'b0;
      bus(1'b1, UMSI_OFS_MASK, 8'hED);
      bus(1'b1, UMSI_OFS_MASK, 8'hEF);
      look(8'hC1, 1'b0);
      $display("source test done");
      end_of_test();
   end
endmodule

// file: sim/umsi_modem_model.sv
// Purpose: modem side model driving the four active-low status pins
// Assumes: the bench asks for asserted lines active high {cd, ri, dsr, cts}
// Notes: pins move 3 ns after an edge, so they arrive unaligned to hclk
`timescale 1ns/1ps
module umsi_modem_model (
   input wire logic hclk,
   input wire logic [3:0] lines,
   output logic carrier_detect_in_n,
   output logic ring_indicator_in_n,
   output logic set_ready_in_n,
   output logic clear_to_send_in_n
);
   // idle pins sit high, an asserted line drives its pin low
   initial begin
      {carrier_detect_in_n, ring_indicator_in_n, set_ready_in_n, clear_to_send_in_n} = 4'hF;
   end
   always @(posedge hclk) begin
      #3 {carrier_detect_in_n, ring_indicator_in_n, set_ready_in_n, clear_to_send_in_n} = ~lines;
   end
endmodule
